/* File: rtdp_deadband.sv */
// Purpose: Delays the rising edge of one PWM output by a programmable count.
// Assumes: Falling edges pass after one register stage.
// Notes: Code 0 gives no extra delay, code n gives 2**n cycles.
module rtdp_deadband
	import rtdp_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic lvl_in,
	input wire logic [2:0] code,
	output logic lvl_out
);
	logic [DB_W:0] cnt_r;
	logic [DB_W:0] cnt_nxt;
	logic out_r;
	logic out_nxt;

	function automatic logic [DB_W:0] db_cycles(input logic [2:0] c);
		db_cycles = (c == 3'h0) ? 9'h000 : (9'h001 << c);
	endfunction : db_cycles

	always_comb begin
		cnt_nxt = cnt_r;
		out_nxt = out_r;
		if (!lvl_in) begin
			cnt_nxt = 9'h000;
			out_nxt = 1'b0;
		end else if (cnt_r >= db_cycles(code)) begin
			out_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 9'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_r <= 9'h000;
			out_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			out_r <= out_nxt;
		end
	end

	assign lvl_out = out_r;
endmodule : rtdp_deadband

/* File: rtdp_pkg.sv */
// Purpose: Shared constants and types for the reload timer with dual PWM outputs.
// Assumes: 8-bit register port with 12-bit byte addresses.
// Notes: Mode encodings combine the mode high bit with the three-bit mode field.
package rtdp_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int CNT_W = 16;
	localparam int PRE_W = 7;
	localparam int DB_W = 8;

	// Register offsets
	localparam logic [11:0] OFS_CNT_HI = 12'hF00;
	localparam logic [11:0] OFS_CNT_LO = 12'hF01;
	localparam logic [11:0] OFS_RLD_HI = 12'hF02;
	localparam logic [11:0] OFS_RLD_LO = 12'hF03;
	localparam logic [11:0] OFS_PWM_HI = 12'hF04;
	localparam logic [11:0] OFS_PWM_LO = 12'hF05;
	localparam logic [11:0] OFS_CTL0 = 12'hF06;
	localparam logic [11:0] OFS_CTL1 = 12'hF07;
	localparam logic [11:0] OFS_STS = 12'hF08;
	localparam logic [11:0] OFS_MSK = 12'hF09;

	// timer_control_one fields
	localparam int C1_RUN = 7;
	localparam int C1_POL = 6;
	localparam int C1_PRE_LSB = 3;
	localparam int C1_MODE_LSB = 0;

	// Second control register fields
	localparam int C0_MODE_HI = 7;
	localparam int C0_ISEL_LSB = 5;
	localparam int C0_DB_LSB = 1;
	localparam int C0_CAP = 0;
	localparam logic [7:0] C0_WR_MASK = 8'hEE;

	// Status and mask bits
	localparam int ST_TMR = 0;
	localparam int ST_CAP = 1;
	localparam logic [7:0] ST_USED = 8'h03;

	// Reset and restart values
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] RLD_RST = 16'h0000;
	localparam logic [15:0] PWM_RST = 16'h0000;
	localparam logic [15:0] CNT_RESTART = 16'h0001;

	// Interrupt source select codes
	localparam logic [1:0] ISEL_CAP_ONLY = 2'h2;
	localparam logic [1:0] ISEL_RLD_ONLY = 2'h3;

	typedef enum logic [3:0] {
		RTDP_MODE_CONT = 4'h1,
		RTDP_MODE_CAPT = 4'h4,
		RTDP_MODE_DUAL = 4'h8
	} rtdp_mode_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} rtdp_req_t;

	typedef struct packed {
		logic pri;
		logic cmp;
	} rtdp_pins_t;
endpackage : rtdp_pkg

/* File: rtdp_timer.sv */
// Purpose: 16-bit reload timer with prescaler, capture and dual PWM outputs.
// Assumes: timer_in is synchronous to clk; register reads answer one cycle later.
// Notes: Outputs with deadband; one level interrupt from sticky status.
// Function
// - A sixteen-bit reloading counter is fed by a prescaler dividing by 1 to 128.
// - In dual PWM mode the counter runs from the prescaler tick and the output toggles on PWM match.
// - On reaching reload in dual PWM mode the timer interrupts, restarts at 0001H and keeps going.
// - Polarity 1 starts high, goes low on match and returns high on reload.
// - Polarity 0 starts low, goes high on match and returns low on reload.
// - While running in dual PWM mode a second output carries the inverse of the primary output apart from deadband; otherwise it is low.
// - Deadband delays only rising edges of both outputs, up to 128 clock cycles.
// - Deadband code 000 means no delay and code n means 2**n cycles, up to 128.
// - Interrupt select upper bit 0 allows all events, 10 capture only, 11 reload/compare only.
// - The capture-cause bit shows whether the latest timer interrupt came from a capture.
// - The top bit of timer_control_one runs the timer when 1 and stops it when 0.
module rtdp_timer
	import rtdp_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input rtdp_req_t req,
	output logic [DATA_W-1:0] rdata,
	input wire logic timer_in,
	output rtdp_pins_t pins,
	output logic irq
);
	logic [7:0] ctl1_r;
	logic [7:0] ctl1_nxt;
	logic [7:0] ctl0_r;
	logic [7:0] ctl0_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [CNT_W-1:0] rld_r;
	logic [CNT_W-1:0] rld_nxt;
	logic [CNT_W-1:0] pwm_r;
	logic [CNT_W-1:0] pwm_nxt;
	logic [PRE_W-1:0] pre_r;
	logic [PRE_W-1:0] pre_nxt;
	logic [7:0] sts_r;
	logic [7:0] sts_nxt;
	logic [7:0] msk_r;
	logic [7:0] msk_nxt;
	logic out_r;
	logic out_nxt;
	logic tin_r;
	logic tin_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;

	logic run;
	logic pol;
	logic [2:0] pre_sel;
	logic [3:0] mode;
	logic [1:0] isel;
	logic [2:0] db_code;
	logic tick;
	logic reload_hit;
	logic match_hit;
	logic rld_ev;
	logic cmp_ev;
	logic cap_ev;
	logic tin_edge;
	logic tmr_irq_ev;
	logic cap_irq_ev;
	logic pri_lvl;
	logic cmp_lvl;
	logic pri_db;
	logic cmp_db;

	function automatic logic [PRE_W-1:0] pre_limit(input logic [2:0] code);
		pre_limit = PRE_W'((8'h01 << code) - 8'h01);
	endfunction : pre_limit

	assign run = ctl1_r[C1_RUN];
	assign pol = ctl1_r[C1_POL];
	assign pre_sel = ctl1_r[C1_PRE_LSB +: 3];
	assign mode = {ctl0_r[C0_MODE_HI], ctl1_r[C1_MODE_LSB +: 3]};
	assign isel = ctl0_r[C0_ISEL_LSB +: 2];
	assign db_code = ctl0_r[C0_DB_LSB +: 3];

	// Prescaler tick; nothing advances while stopped
	assign tick = run && (pre_r == pre_limit(pre_sel));
	assign reload_hit = tick && (cnt_r == rld_r);
	assign match_hit = tick && (cnt_r == pwm_r) && (mode == RTDP_MODE_DUAL);

	// Input edge in the polarity's sense; pin rate is bounded by the far side
	assign tin_edge = (timer_in != tin_r) && (timer_in != pol);

	assign rld_ev = reload_hit;
	assign cmp_ev = match_hit;
	assign cap_ev = run && tin_edge && (mode == RTDP_MODE_CAPT);

	// Source selection for the timer interrupt
	always_comb begin
		tmr_irq_ev = 1'b0;
		cap_irq_ev = 1'b0;
		if (isel == ISEL_CAP_ONLY) begin
			cap_irq_ev = cap_ev;
		end else if (isel == ISEL_RLD_ONLY) begin
			tmr_irq_ev = rld_ev || cmp_ev;
		end else begin
			tmr_irq_ev = rld_ev || cmp_ev;
			cap_irq_ev = cap_ev;
		end
	end

	always_comb begin
		ctl1_nxt = ctl1_r;
		ctl0_nxt = ctl0_r;
		cnt_nxt = cnt_r;
		rld_nxt = rld_r;
		pwm_nxt = pwm_r;
		pre_nxt = pre_r;
		sts_nxt = sts_r;
		msk_nxt = msk_r;
		out_nxt = out_r;
		tin_nxt = timer_in;
		rdata_nxt = rdata_r;

		// Prescaler
		if (!run) begin
			pre_nxt = 7'h00;
		end else if (tick) begin
			pre_nxt = 7'h00;
		end else begin
			pre_nxt = pre_r + 7'h01;
		end

		// Counter: restart at 0001H on reload, hold while stopped
		if (reload_hit) begin
			cnt_nxt = CNT_RESTART;
		end else if (tick) begin
			cnt_nxt = cnt_r + 16'h0001;
		end

		// Primary output level
		if (!run || mode != RTDP_MODE_DUAL) begin
			out_nxt = pol;
		end else if (reload_hit) begin
			out_nxt = pol;
		end else if (match_hit) begin
			out_nxt = ~out_r;
		end

		// Capture stores the count in the PWM/capture register
		if (cap_ev) begin
			pwm_nxt = cnt_r;
		end

		// Cause bit follows the most recent interrupt event
		if (cap_irq_ev) begin
			ctl0_nxt[C0_CAP] = 1'b1;
		end else if (tmr_irq_ev) begin
			ctl0_nxt[C0_CAP] = 1'b0;
		end

		// Register writes
		if (req.wr) begin
			case (req.addr)
				OFS_CNT_HI: cnt_nxt[15:8] = req.wdata;
				OFS_CNT_LO: cnt_nxt[7:0] = req.wdata;
				OFS_RLD_HI: rld_nxt[15:8] = req.wdata;
				OFS_RLD_LO: rld_nxt[7:0] = req.wdata;
				OFS_PWM_HI: pwm_nxt[15:8] = req.wdata;
				OFS_PWM_LO: pwm_nxt[7:0] = req.wdata;
				OFS_CTL0: begin
					ctl0_nxt = (req.wdata & C0_WR_MASK) | (ctl0_nxt & ~C0_WR_MASK);
				end
				OFS_CTL1: ctl1_nxt = req.wdata;
				OFS_STS: sts_nxt = sts_r & ~req.wdata;
				OFS_MSK: msk_nxt = req.wdata & ST_USED;
				default: ;
			endcase
		end

		// Sticky events win over a same-cycle clear
		if (tmr_irq_ev) begin
			sts_nxt[ST_TMR] = 1'b1;
		end
		if (cap_irq_ev) begin
			sts_nxt[ST_CAP] = 1'b1;
		end

		// Register reads answer in the next cycle
		if (req.rd) begin
			case (req.addr)
				OFS_CNT_HI: rdata_nxt = cnt_r[15:8];
				OFS_CNT_LO: rdata_nxt = cnt_r[7:0];
				OFS_RLD_HI: rdata_nxt = rld_r[15:8];
				OFS_RLD_LO: rdata_nxt = rld_r[7:0];
				OFS_PWM_HI: rdata_nxt = pwm_r[15:8];
				OFS_PWM_LO: rdata_nxt = pwm_r[7:0];
				OFS_CTL0: rdata_nxt = ctl0_r;
				OFS_CTL1: rdata_nxt = ctl1_r;
				OFS_STS: rdata_nxt = sts_r;
				OFS_MSK: rdata_nxt = msk_r;
				default: rdata_nxt = 8'h00;
			endcase
		end else begin
			rdata_nxt = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ctl1_r <= CTL_RST;
			ctl0_r <= CTL_RST;
			cnt_r <= CNT_RST;
			rld_r <= RLD_RST;
			pwm_r <= PWM_RST;
			pre_r <= 7'h00;
			sts_r <= 8'h00;
			msk_r <= 8'h00;
			out_r <= 1'b0;
			tin_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			ctl1_r <= ctl1_nxt;
			ctl0_r <= ctl0_nxt;
			cnt_r <= cnt_nxt;
			rld_r <= rld_nxt;
			pwm_r <= pwm_nxt;
			pre_r <= pre_nxt;
			sts_r <= sts_nxt;
			msk_r <= msk_nxt;
			out_r <= out_nxt;
			tin_r <= tin_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Complement output only in dual mode; otherwise held low
	assign pri_lvl = out_r;
	assign cmp_lvl = (run && mode == RTDP_MODE_DUAL) ? ~out_r : 1'b0;

	rtdp_deadband u_db_pri (
		.clk(clk),
		.srst(srst),
		.lvl_in(pri_lvl),
		.code(db_code),
		.lvl_out(pri_db)
	);

	rtdp_deadband u_db_cmp (
		.clk(clk),
		.srst(srst),
		.lvl_in(cmp_lvl),
		.code(db_code),
		.lvl_out(cmp_db)
	);

	// One driver for the whole pin struct
	assign pins = '{pri: pri_db, cmp: cmp_db};
	assign rdata = rdata_r;
	assign irq = |(sts_r & msk_r);
endmodule : rtdp_timer

/* File: rtdp_timer_checker.sv */
// Purpose: Port-level checker for rtdp_timer.
// Assumes: One clock, srst synchronous active high.
// Notes: Bound from the bench top file.
module rtdp_timer_checker
	import rtdp_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input rtdp_req_t req,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic timer_in,
	input rtdp_pins_t pins,
	input wire logic irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	a_outputs_exclusive: assert property (!(pins.pri && pins.cmp))
		else $error("pri and cmp high together");
	a_rdata_idle: assert property (!req.rd |=> rdata == 8'h00)
		else $error("rdata not zero outside read");
	a_unmapped_zero: assert property (req.rd && (req.addr < OFS_CNT_HI || req.addr > OFS_MSK)
		|=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_ctl1_readback: assert property (req.wr && req.addr == OFS_CTL1 ##2 req.rd
		&& req.addr == OFS_CTL1 |=> rdata == $past(req.wdata, 3))
		else $error("control one readback wrong");
	a_ctl0_reserved: assert property (req.rd && req.addr == OFS_CTL0 |=> !rdata[4])
		else $error("reserved control bit set");
	a_status_unused: assert property (req.rd && req.addr == OFS_STS
		|=> (rdata & ~ST_USED) == 8'h00)
		else $error("unused status bits set");
	a_irq_fall_cause: assert property ($fell(irq) |-> $past(req.wr)
		&& ($past(req.addr) == OFS_STS || $past(req.addr) == OFS_MSK))
		else $error("irq dropped without clear or mask write");
	a_reset_quiet: assert property ($past(srst) |-> pins == 2'b00 && !irq && rdata == 8'h00)
		else $error("outputs active after reset");
	cover property ($rose(irq));
	cover property ($rose(pins.pri));
	cover property ($rose(pins.cmp));
endmodule : rtdp_timer_checker

/* File: rtdp_timer_tb_top.sv */
// Purpose: Self-checking bench for rtdp_timer.
// Assumes: 250 MHz clock, reset held 10 cycles.
// Notes: PWM checks count high cycles over five whole periods.
module rtdp_timer_tb_top
	import rtdp_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic timer_in = 1'b0;
	rtdp_req_t req = '0;
	logic [7:0] rdata;
	rtdp_pins_t pins;
	logic irq;
	int n_fail = 0;
	int n_checks = 0;
	logic [7:0] np;
	logic [7:0] nc;
	// Rows: pol0 db0 all, pol1 db1 capture only, pol0 db2 reload only
	localparam logic [7:0] C0 [3] = '{8'h80, 8'hC2, 8'hE4};
	localparam logic [7:0] C1 [3] = '{8'h80, 8'hC0, 8'h80};
	localparam logic [7:0] EP [3] = '{8'h32, 8'h14, 8'h1E};
	localparam logic [7:0] EC [3] = '{8'h1E, 8'h28, 8'h0A};
	localparam logic [7:0] ES [3] = '{8'h01, 8'h00, 8'h01};
	rtdp_timer rtdp_timer_inst (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
		.timer_in(timer_in), .pins(pins), .irq(irq));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		@(negedge clk);
		chk("rdata", rdata & m, e);
	endtask : rd
	task automatic irq_is(input logic e);
		@(negedge clk);
		chk("irq", {7'h00, irq}, {7'h00, e});
	endtask : irq_is
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			rd(12'(OFS_CNT_HI + i), 8'h00, 8'hFF);
		end
		wr(12'h0A0, 8'hFF);
		rd(12'h0A0, 8'h00, 8'hFF);
		wr(OFS_CTL1, 8'h78);
		rd(OFS_CTL1, 8'h78, 8'hFF);
		wr(OFS_CNT_LO, 8'h05);
		repeat (20) @(posedge clk);
		rd(OFS_CNT_LO, 8'h05, 8'hFF);
		wr(OFS_RLD_LO, 8'h10);
		wr(OFS_PWM_LO, 8'h06);
		wr(OFS_MSK, 8'h03);
		for (int r = 0; r < 3; r++) begin
			wr(OFS_CTL1, 8'h00);
			wr(OFS_STS, 8'hFF);
			irq_is(1'b0);
			wr(OFS_CTL0, C0[r]);
			wr(OFS_CNT_LO, 8'h01);
			wr(OFS_CTL1, C1[r]);
			repeat (40) @(posedge clk);
			np = 8'h00;
			nc = 8'h00;
			repeat (80) begin
				@(negedge clk);
				np = np + {7'h00, pins.pri};
				nc = nc + {7'h00, pins.cmp};
			end
			chk("pri", np, EP[r]);
			chk("cmp", nc, EC[r]);
			irq_is(ES[r][0]);
			wr(OFS_CTL1, 8'h00);
			rd(OFS_STS, ES[r], 8'hFF);
		end
		wr(OFS_MSK, 8'h00);
		irq_is(1'b0);
		wr(OFS_MSK, 8'h01);
		irq_is(1'b1);
		wr(OFS_STS, 8'h01);
		irq_is(1'b0);
		wr(OFS_CTL0, 8'h00);
		wr(OFS_CNT_LO, 8'h01);
		wr(OFS_CTL1, 8'hBC);
		repeat (4) @(posedge clk);
		timer_in <= 1'b1;
		repeat (4) @(posedge clk);
		rd(OFS_CTL0, 8'h01, 8'h01);
		rd(OFS_STS, 8'h02, 8'h02);
		rd(OFS_PWM_LO, 8'h01, 8'hFF);
		wr(OFS_CTL1, 8'h00);
		wr(OFS_CTL0, 8'h80);
		wr(OFS_CTL1, 8'h80);
		repeat (20) @(posedge clk);
		rd(OFS_CTL0, 8'h00, 8'h01);
		wr(OFS_CTL1, 8'h00);
		end_of_test();
	end
endmodule : rtdp_timer_tb_top

bind rtdp_timer rtdp_timer_checker rtdp_timer_checker_inst (.clk(clk), .srst(srst), .req(req),
	.rdata(rdata), .timer_in(timer_in), .pins(pins), .irq(irq));
